// ### verilog/dspdec_pkg.sv
// shared constants and types for the opcode decoder block
package dspdec_pkg;
   // apb register byte offsets
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_FIELDS = 8'h0c;
   localparam logic [7:0] REG_CONST = 8'h10;
   localparam logic [7:0] REG_STBITS = 8'h14;
   localparam int REG_AW = 8;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // flags register layout, written by software for the return condition
   localparam int FLG_C = 0;
   localparam int FLG_V = 1;
   localparam int FLG_L = 2;
   localparam int FLG_Z = 3;
   localparam int FLG_TC = 4;
   localparam int FLG_BIO = 5;
   localparam int FLG_W = 6;
   localparam logic [FLG_W-1:0] FLG_RST = 6'h00;
   // status bit ids reported for the status-bit-set instruction
   localparam int SB_N = 7;
   localparam logic [2:0] SB_CARRY = 3'h0;
   localparam logic [2:0] SB_BLK_PRG = 3'h1;
   localparam logic [2:0] SB_INT_DIS = 3'h2;
   localparam logic [2:0] SB_OVF_MODE = 3'h3;
   localparam logic [2:0] SB_TEST = 3'h4;
   localparam logic [2:0] SB_EXT = 3'h5;
   localparam logic [2:0] SB_SIGN_EXT = 3'h6;
   localparam logic [2:0] SB_NONE = 3'h7;
   localparam logic [3:0] SEL_CARRY = 4'hf;
   localparam logic [3:0] SEL_BLK_PRG = 4'h5;
   localparam logic [3:0] SEL_INT_DIS = 4'h1;
   localparam logic [3:0] SEL_OVF_MODE = 4'h3;
   localparam logic [3:0] SEL_TEST = 4'hb;
   localparam logic [3:0] SEL_EXT = 4'hd;
   localparam logic [3:0] SEL_SIGN_EXT = 4'h7;
   // whole-word patterns
   localparam logic [15:0] W_PROD_TO_ACC = 16'hbe03;
   localparam logic [15:0] W_POP_ACC = 16'hbe32;
   localparam logic [15:0] W_PUSH_ACC = 16'hbe3c;
   localparam logic [15:0] W_OR_IMM_16 = 16'hbe82;
   // masked patterns
   localparam logic [15:0] MSK_LO4 = 16'hfff0;
   localparam logic [15:0] MSK_LO3 = 16'hfff8;
   localparam logic [15:0] MSK_LO2 = 16'hfffc;
   localparam logic [15:0] MSK_TOP4 = 16'hf000;
   localparam logic [15:0] MSK_TOP5 = 16'hf800;
   localparam logic [15:0] MSK_TOP6 = 16'hfc00;
   localparam logic [15:0] P_STATUS_SET = 16'hbe40;
   localparam logic [15:0] P_PROD_SHIFT = 16'hbf00;
   localparam logic [15:0] P_OR_SHIFT = 16'hbfc0;
   localparam logic [15:0] P_AUX_PTR = 16'h8b88;
   localparam logic [15:0] P_ACC_HIGH = 16'h9800;
   localparam logic [15:0] P_ACC_LOW = 16'h9000;
   localparam logic [15:0] P_COND_RET = 16'hec00;
   localparam logic [15:0] P_SUB_SHIFT = 16'h3000;
   // upper-byte patterns
   localparam logic [7:0] HI_MUL_ACC_MOVE = 8'ha3;
   localparam logic [7:0] HI_AUX_MODIFY = 8'h8b;
   localparam logic [7:0] HI_MULTIPLY = 8'h54;
   localparam logic [7:0] HI_MUL_ADD = 8'h50;
   localparam logic [7:0] HI_MUL_SUB = 8'h51;
   localparam logic [7:0] HI_NORMALISE = 8'ha0;
   localparam logic [7:0] HI_STACK_TO_MEM = 8'h8a;
   localparam logic [7:0] HI_MEM_TO_STACK = 8'h76;
   localparam logic [7:0] HI_REPEAT_IMM = 8'hbb;
   localparam logic [7:0] HI_REPEAT_MEM = 8'h0b;
   localparam logic [7:0] HI_AUX_SUB = 8'h7c;
   localparam logic [7:0] HI_STATUS_ONE = 8'h8f;
   localparam logic [7:0] HI_STATUS_ZERO = 8'h8e;
   localparam logic [7:0] HI_STORE_LONG = 8'hae;
   localparam logic [7:0] HI_SUB_HIGH = 8'h65;
   localparam logic [7:0] HI_SQUARE_SUB = 8'h53;
   // return test-bit codes
   localparam logic [1:0] TP_BIO_LOW = 2'h0;
   localparam logic [1:0] TP_TC_SET = 2'h1;
   localparam logic [1:0] TP_TC_CLR = 2'h2;
   // word and cycle counts
   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;
   // result register layout
   localparam int RES_WORDS = 5;
   localparam int RES_CYC = 8;
   localparam int RES_VALID = 12;
   localparam int RES_PEND = 13;
   localparam int RES_TAKEN = 14;
   // fields register layout
   localparam int FLD_IND = 8;
   localparam int FLD_DMA = 9;
   localparam int FLD_MOD = 16;
   localparam int FLD_NXT = 19;
   localparam int FLD_AUX = 20;
   localparam int FLD_SHF = 23;
   localparam int FLD_SB = 27;
   localparam int FLD_PM = 30;
   localparam int CST_IMM = 16;

   typedef enum logic [4:0] {
      OP_NONE, OP_MUL_ACC_MOVE, OP_AUX_PTR_LOAD, OP_AUX_MODIFY, OP_MULTIPLY, OP_MUL_ADD_PREV,
      OP_MUL_SUB_PREV, OP_NORMALISE, OP_OR_IMM_SHIFT, OP_OR_IMM_16, OP_PRODUCT_TO_ACC, OP_POP_ACC,
      OP_PUSH_ACC, OP_STACK_TO_MEM, OP_MEM_TO_STACK, OP_COND_RETURN, OP_REPEAT_IMM, OP_REPEAT_MEM,
      OP_STORE_ACC_HIGH, OP_STORE_ACC_LOW, OP_AUX_SUB_IMM, OP_STATUS_BIT_SET, OP_PRODUCT_SHIFT_MODE,
      OP_STATUS_STORE_ZERO, OP_STATUS_STORE_ONE, OP_STORE_LONG_IMM, OP_SUB_SHIFT, OP_SUB_HIGH, OP_SQUARE_SUB
   } dspdec_op_e;

   typedef enum logic {ST_FIRST, ST_CONST} dspdec_state_e;
endpackage

// ### verilog/dspdec_top.sv
// apb-accessed opcode decoder for the multiply through subtract instruction group
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps

module dspdec_top #(
   parameter int ADDR_W = 8
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // apb answer
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // decoded controls toward the datapath
   output logic dec_valid,
   output logic [4:0] dec_op,
   output logic [2:0] dec_cycles,
   output logic external_flag_output
);

   // the decode of the low eight offset bits needs at least eight address bits
   generate
      if (ADDR_W < dspdec_pkg::REG_AW || ADDR_W > 32)
      begin : g_bad_width
         $error("dspdec_top: ADDR_W must lie between 8 and 32");
      end
   endgenerate

   // apb state
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   // decoder state
   dspdec_pkg::dspdec_state_e state_ff;
   dspdec_pkg::dspdec_op_e op_ff;
   logic [1:0] words_ff;
   logic [2:0] cycles_ff;
   logic valid_ff;
   logic taken_ff;
   logic strobe_ff;
   logic [7:0] lo_ff;
   logic [3:0] shift_ff;
   logic [2:0] aux_ff;
   logic [2:0] sb_ff;
   logic [1:0] pm_ff;
   logic [15:0] const_ff;
   logic [dspdec_pkg::FLG_W-1:0] flags_ff;
   logic [dspdec_pkg::SB_N-1:0] stbits_ff;

   // apb phase decode; a transfer takes effect only on its ready edge
   logic access;
   logic commit;
   logic [7:0] off;
   logic hi_zero;
   logic hit_instr;
   logic hit_flags;
   logic hit_result;
   logic hit_fields;
   logic hit_const;
   logic hit_stbits;
   logic hit_any;
   logic ro_write;
   assign access = psel & penable;
   assign commit = access & pready_ff;
   assign off = paddr[7:0];
   assign hi_zero = (paddr >> dspdec_pkg::REG_AW) == '0;
   assign hit_instr = hi_zero & (off == dspdec_pkg::REG_INSTR);
   assign hit_flags = hi_zero & (off == dspdec_pkg::REG_FLAGS);
   assign hit_result = hi_zero & (off == dspdec_pkg::REG_RESULT);
   assign hit_fields = hi_zero & (off == dspdec_pkg::REG_FIELDS);
   assign hit_const = hi_zero & (off == dspdec_pkg::REG_CONST);
   assign hit_stbits = hi_zero & (off == dspdec_pkg::REG_STBITS);
   assign hit_any = hit_instr | hit_flags | hit_result | hit_fields | hit_const | hit_stbits;
   // writes to read-only words are refused with an error rather than dropped silently
   assign ro_write = pwrite & (hit_result | hit_fields | hit_const);

   logic wr_instr;
   logic wr_flags;
   logic wr_stbits;
   assign wr_instr = commit & pwrite & hit_instr;
   assign wr_flags = commit & pwrite & hit_flags;
   assign wr_stbits = commit & pwrite & hit_stbits;

   // instruction word and its upper byte
   logic [15:0] w;
   logic [7:0] hi;
   assign w = pwdata[15:0];
   assign hi = w[15:8];

   // whole-word and masked matches; exact words are tested before wider patterns
   logic m_prod_acc;
   logic m_pop;
   logic m_push;
   logic m_or16;
   logic m_stset;
   logic m_pshift;
   logic m_orsh;
   logic m_aux_ptr;
   logic m_store_hi;
   logic m_store_lo;
   logic m_cret;
   logic m_sub;
   logic [2:0] sel_sb;
   assign m_prod_acc = w == dspdec_pkg::W_PROD_TO_ACC;
   assign m_pop = w == dspdec_pkg::W_POP_ACC;
   assign m_push = w == dspdec_pkg::W_PUSH_ACC;
   assign m_or16 = w == dspdec_pkg::W_OR_IMM_16;
   assign m_stset = ((w & dspdec_pkg::MSK_LO4) == dspdec_pkg::P_STATUS_SET) & (sel_sb != dspdec_pkg::SB_NONE);
   assign m_pshift = (w & dspdec_pkg::MSK_LO2) == dspdec_pkg::P_PROD_SHIFT;
   assign m_orsh = (w & dspdec_pkg::MSK_LO4) == dspdec_pkg::P_OR_SHIFT;
   assign m_aux_ptr = (w & dspdec_pkg::MSK_LO3) == dspdec_pkg::P_AUX_PTR;
   assign m_store_hi = (w & dspdec_pkg::MSK_TOP5) == dspdec_pkg::P_ACC_HIGH;
   assign m_store_lo = (w & dspdec_pkg::MSK_TOP5) == dspdec_pkg::P_ACC_LOW;
   assign m_cret = (w & dspdec_pkg::MSK_TOP6) == dspdec_pkg::P_COND_RET;
   assign m_sub = (w & dspdec_pkg::MSK_TOP4) == dspdec_pkg::P_SUB_SHIFT;

   // status bit picked by the low nibble; the reset-bit codes fall outside this group
   assign sel_sb = (w[3:0] == dspdec_pkg::SEL_CARRY) ? dspdec_pkg::SB_CARRY :
      (w[3:0] == dspdec_pkg::SEL_BLK_PRG) ? dspdec_pkg::SB_BLK_PRG :
      (w[3:0] == dspdec_pkg::SEL_INT_DIS) ? dspdec_pkg::SB_INT_DIS :
      (w[3:0] == dspdec_pkg::SEL_OVF_MODE) ? dspdec_pkg::SB_OVF_MODE :
      (w[3:0] == dspdec_pkg::SEL_TEST) ? dspdec_pkg::SB_TEST :
      (w[3:0] == dspdec_pkg::SEL_EXT) ? dspdec_pkg::SB_EXT :
      (w[3:0] == dspdec_pkg::SEL_SIGN_EXT) ? dspdec_pkg::SB_SIGN_EXT : dspdec_pkg::SB_NONE;

   // opcode selection in priority order
   dspdec_pkg::dspdec_op_e nxt_op;
   // the wide 8b upper-byte match would swallow the masked pointer-load words, so those are tested first
   assign nxt_op = m_prod_acc ? dspdec_pkg::OP_PRODUCT_TO_ACC :
      m_pop ? dspdec_pkg::OP_POP_ACC :
      m_push ? dspdec_pkg::OP_PUSH_ACC :
      m_or16 ? dspdec_pkg::OP_OR_IMM_16 :
      m_stset ? dspdec_pkg::OP_STATUS_BIT_SET :
      m_pshift ? dspdec_pkg::OP_PRODUCT_SHIFT_MODE :
      m_orsh ? dspdec_pkg::OP_OR_IMM_SHIFT :
      m_aux_ptr ? dspdec_pkg::OP_AUX_PTR_LOAD :
      (hi == dspdec_pkg::HI_AUX_MODIFY) ? dspdec_pkg::OP_AUX_MODIFY :
      (hi == dspdec_pkg::HI_MUL_ACC_MOVE) ? dspdec_pkg::OP_MUL_ACC_MOVE :
      (hi == dspdec_pkg::HI_MULTIPLY) ? dspdec_pkg::OP_MULTIPLY :
      (hi == dspdec_pkg::HI_MUL_ADD) ? dspdec_pkg::OP_MUL_ADD_PREV :
      (hi == dspdec_pkg::HI_MUL_SUB) ? dspdec_pkg::OP_MUL_SUB_PREV :
      (hi == dspdec_pkg::HI_NORMALISE) ? dspdec_pkg::OP_NORMALISE :
      (hi == dspdec_pkg::HI_STACK_TO_MEM) ? dspdec_pkg::OP_STACK_TO_MEM :
      (hi == dspdec_pkg::HI_MEM_TO_STACK) ? dspdec_pkg::OP_MEM_TO_STACK :
      (hi == dspdec_pkg::HI_REPEAT_IMM) ? dspdec_pkg::OP_REPEAT_IMM :
      (hi == dspdec_pkg::HI_REPEAT_MEM) ? dspdec_pkg::OP_REPEAT_MEM :
      (hi == dspdec_pkg::HI_AUX_SUB) ? dspdec_pkg::OP_AUX_SUB_IMM :
      (hi == dspdec_pkg::HI_STATUS_ONE) ? dspdec_pkg::OP_STATUS_STORE_ONE :
      (hi == dspdec_pkg::HI_STATUS_ZERO) ? dspdec_pkg::OP_STATUS_STORE_ZERO :
      (hi == dspdec_pkg::HI_STORE_LONG) ? dspdec_pkg::OP_STORE_LONG_IMM :
      (hi == dspdec_pkg::HI_SUB_HIGH) ? dspdec_pkg::OP_SUB_HIGH :
      (hi == dspdec_pkg::HI_SQUARE_SUB) ? dspdec_pkg::OP_SQUARE_SUB :
      m_store_hi ? dspdec_pkg::OP_STORE_ACC_HIGH :
      m_store_lo ? dspdec_pkg::OP_STORE_ACC_LOW :
      m_cret ? dspdec_pkg::OP_COND_RETURN :
      m_sub ? dspdec_pkg::OP_SUB_SHIFT : dspdec_pkg::OP_NONE;

   // return condition: high nibble selects flags, low nibble gives wanted values
   logic [3:0] condition_flag_field;
   logic flags_ok;
   logic tp_ok;
   logic cond_taken;
   assign condition_flag_field = {flags_ff[dspdec_pkg::FLG_Z], flags_ff[dspdec_pkg::FLG_L],
                                  flags_ff[dspdec_pkg::FLG_V], flags_ff[dspdec_pkg::FLG_C]};
   assign flags_ok = &(~w[7:4] | ~(condition_flag_field ^ w[3:0]));
   assign tp_ok = (w[9:8] == dspdec_pkg::TP_BIO_LOW) ? ~flags_ff[dspdec_pkg::FLG_BIO] :
      (w[9:8] == dspdec_pkg::TP_TC_SET) ? flags_ff[dspdec_pkg::FLG_TC] :
      (w[9:8] == dspdec_pkg::TP_TC_CLR) ? ~flags_ff[dspdec_pkg::FLG_TC] : 1'b1;
   assign cond_taken = flags_ok & tp_ok;

   // word and cycle counts of the decoded instruction
   // the accumulate-with-move count is a chosen value; software must not rely on it
   // beyond ordering, since the datapath timing behind it is outside this block
   logic two_word;
   logic [1:0] nxt_words;
   logic [2:0] nxt_cycles;
   assign two_word = (nxt_op == dspdec_pkg::OP_MUL_ACC_MOVE) | (nxt_op == dspdec_pkg::OP_OR_IMM_SHIFT) |
      (nxt_op == dspdec_pkg::OP_OR_IMM_16) | (nxt_op == dspdec_pkg::OP_STORE_LONG_IMM);
   assign nxt_words = two_word ? dspdec_pkg::WORDS_TWO : dspdec_pkg::WORDS_ONE;
   assign nxt_cycles = (nxt_op == dspdec_pkg::OP_MUL_ACC_MOVE) ? dspdec_pkg::CYC_THREE :
      (nxt_op == dspdec_pkg::OP_COND_RETURN) ?
         (cond_taken ? dspdec_pkg::CYC_FOUR : dspdec_pkg::CYC_TWO) :
      two_word ? dspdec_pkg::CYC_TWO : dspdec_pkg::CYC_ONE;

   // shift field location differs between the store, subtract and or forms
   logic [3:0] nxt_shift;
   assign nxt_shift = (m_store_hi | m_store_lo) ? {1'b0, w[10:8]} :
      m_sub ? w[11:8] :
      m_orsh ? w[3:0] : 4'h0;

   // aux select: pointer load takes the low three bits; indirect forms name the next aux
   logic [2:0] nxt_aux;
   assign nxt_aux = w[2:0];

   // address decoding of the first word's low byte
   logic ind_mode;
   logic [6:0] dma;
   logic [2:0] ind_mod;
   logic ind_next;
   assign ind_mode = lo_ff[7];
   assign dma = ind_mode ? 7'h00 : lo_ff[6:0];
   assign ind_mod = ind_mode ? lo_ff[6:4] : 3'h0;
   assign ind_next = ind_mode & lo_ff[3];

   // sequencing: a two-word instruction waits for its constant in the next instruction write
   dspdec_pkg::dspdec_state_e nxt_state;
   logic first_done;
   logic const_done;
   assign first_done = wr_instr & (state_ff == dspdec_pkg::ST_FIRST);
   assign const_done = wr_instr & (state_ff == dspdec_pkg::ST_CONST);
   assign nxt_state = (first_done & two_word) ? dspdec_pkg::ST_CONST :
      const_done ? dspdec_pkg::ST_FIRST : state_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= dspdec_pkg::ST_FIRST;
      else
         state_ff <= nxt_state;
   end

   // latch the first word's decode; later words leave it standing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_ff <= dspdec_pkg::OP_NONE;
         words_ff <= 2'h0;
         cycles_ff <= 3'h0;
         taken_ff <= 1'b0;
         lo_ff <= 8'h00;
         shift_ff <= 4'h0;
         aux_ff <= 3'h0;
         sb_ff <= dspdec_pkg::SB_NONE;
         pm_ff <= 2'h0;
      end
      else if (first_done)
      begin
         op_ff <= nxt_op;
         words_ff <= nxt_words;
         cycles_ff <= nxt_cycles;
         taken_ff <= (nxt_op == dspdec_pkg::OP_COND_RETURN) & cond_taken;
         lo_ff <= w[7:0];
         shift_ff <= nxt_shift;
         aux_ff <= nxt_aux;
         sb_ff <= m_stset ? sel_sb : dspdec_pkg::SB_NONE;
         pm_ff <= m_pshift ? w[1:0] : 2'h0;
      end
   end

   // second word capture, valid flag and the one-cycle completion pulse
   logic nxt_valid;
   logic nxt_strobe;
   assign nxt_valid = (first_done & ~two_word) | const_done | (valid_ff & ~first_done);
   assign nxt_strobe = (first_done & ~two_word) | const_done;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         const_ff <= 16'h0000;
         valid_ff <= 1'b0;
         strobe_ff <= 1'b0;
      end
      else
      begin
         const_ff <= const_done ? w : const_ff;
         valid_ff <= nxt_valid;
         strobe_ff <= nxt_strobe;
      end
   end

   // condition flags, written by software before a conditional return is decoded
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_ff <= dspdec_pkg::FLG_RST;
      else if (wr_flags)
         flags_ff <= pwdata[dspdec_pkg::FLG_W-1:0];
   end

   // sticky status bits: the decoder sets, software writes one to clear, set wins a tie
   genvar gi;
   generate
      for (gi = 0; gi < dspdec_pkg::SB_N; gi++)
      begin : g_stbit
         logic set_bit;
         logic clr_bit;
         assign set_bit = first_done & m_stset & (sel_sb == 3'(gi));
         assign clr_bit = wr_stbits & pwdata[gi];
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               stbits_ff[gi] <= 1'b0;
            else
               stbits_ff[gi] <= set_bit | (stbits_ff[gi] & ~clr_bit);
         end
      end
   endgenerate

   // read words assembled from the decoded state
   logic [31:0] rd_result;
   logic [31:0] rd_fields;
   logic [31:0] rd_const;
   logic [31:0] rd_data;
   assign rd_result = {17'h00000, taken_ff, (state_ff == dspdec_pkg::ST_CONST), valid_ff,
                       1'b0, cycles_ff, 1'b0, words_ff, op_ff};
   assign rd_fields = {pm_ff, sb_ff, shift_ff, aux_ff, ind_next, ind_mod, dma, ind_mode, lo_ff};
   assign rd_const = {8'h00, lo_ff, const_ff};
   assign rd_data = hit_result ? rd_result :
      hit_fields ? rd_fields :
      hit_const ? rd_const :
      hit_flags ? {26'h0000000, flags_ff} :
      hit_stbits ? {25'h0000000, stbits_ff} : dspdec_pkg::RST_WORD;

   // one wait state: ready rises in the second access cycle, data and error land with it
   // the fixed wait costs a cycle per access but keeps read data fully registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= dspdec_pkg::RST_WORD;
      end
      else
      begin
         pready_ff <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & (~hit_any | ro_write);
         prdata_ff <= (access & ~pready_ff & ~pwrite) ? rd_data : dspdec_pkg::RST_WORD;
      end
   end

   // outputs straight from flip-flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign dec_valid = strobe_ff;
   assign dec_op = op_ff;
   assign dec_cycles = cycles_ff;
   assign external_flag_output = stbits_ff[dspdec_pkg::SB_EXT];

endmodule

// ### tb/dspdec_asserts.sv
// concurrent checks on the opcode decoder ports
`timescale 1ns/1ps
module dspdec_chk #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // decode
   input wire logic dec_valid,
   input wire logic [4:0] dec_op,
   input wire logic [2:0] dec_cycles,
   input wire logic external_flag_output
);
   // accepted write to the instruction word, the only cause of a decode
   wire logic wr0 = psel & penable & pready & pwrite & ~pslverr & (paddr == '0);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
      else $error("ready not one cycle after access");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_VALID_CAUSE: assert property (dec_valid |-> $past(wr0))
      else $error("decode without instruction write");
   AST_AUX_PTR: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_AUX_PTR_LOAD |-> dec_cycles == dspdec_pkg::CYC_ONE)
      else $error("pointer load cycles wrong");
   AST_MUL: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_MULTIPLY |-> dec_cycles == dspdec_pkg::CYC_ONE)
      else $error("multiply cycles wrong");
   AST_OR_SHIFT: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_OR_IMM_SHIFT |-> dec_cycles == dspdec_pkg::CYC_TWO ##1 !dec_valid)
      else $error("or shift cycles wrong");
   AST_OR16: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_OR_IMM_16 |-> dec_cycles == dspdec_pkg::CYC_TWO)
      else $error("or sixteen cycles wrong");
   AST_RET: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_COND_RETURN |-> dec_cycles inside {3'h2, 3'h4})
      else $error("return cycles wrong");
   AST_STLONG: assert property (
      dec_valid && dec_op == dspdec_pkg::OP_STORE_LONG_IMM |-> dec_cycles == dspdec_pkg::CYC_TWO)
      else $error("store long cycles wrong");
   AST_EXT: assert property ($rose(external_flag_output) |-> dec_op == dspdec_pkg::OP_STATUS_BIT_SET)
      else $error("external flag rose without status set");
endmodule

bind dspdec_top dspdec_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .dec_valid(dec_valid), .dec_op(dec_op), .dec_cycles(dec_cycles),
   .external_flag_output(external_flag_output));

// ### tb/dspdec_prog_mem.sv
// program memory model: instruction words, constant word after two-word opcodes
`timescale 1ns/1ps
module dspdec_prog_mem (
   // fetch
   input wire logic [5:0] pm_addr,
   output logic [15:0] pm_word
);
   localparam logic [15:0] ROM [0:30] = '{
      16'h5412, 16'h5000, 16'h5100, 16'ha080, 16'hbe03, 16'hbe32, 16'hbe3c, 16'h8a10,
      16'h7611, 16'hbb05, 16'h0b22, 16'h9a33, 16'h9233, 16'h7c07, 16'hbf01, 16'h8e44,
      16'h8f44, 16'h3512, 16'h6512, 16'h5301, 16'h8b8a, 16'h8b90, 16'ha312, 16'h1234,
      16'hbfc4, 16'h00ff, 16'hbe82, 16'h0f0f, 16'hae80, 16'hbeef, 16'hffff};
   // past the table the bus shows the address xored with a5a5, never a stale word
   assign pm_word = (pm_addr < 6'h1f) ? ROM[pm_addr] : {10'h0, pm_addr} ^ 16'ha5a5;
endmodule

// ### tb/dspdec_top_bench.sv
// self-checking bench for the opcode decoder over apb
`timescale 1ns/1ps
`define CHK(g, x) \
   checks_done++; \
   if ((g) !== (x)) \
   begin \
      n_errors++; \
      $display("unexpected at %0t: got %h want %h", $time, (g), (x)); \
   end
module dspdec_top_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, dec_valid, external_flag_output, er;
   logic [4:0] dec_op;
   logic [2:0] dec_cycles;
   logic [8:0] dv;
   logic [5:0] pm_addr = 6'h00;
   logic [15:0] pm_word;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   // expected {op, cycles, words} per instruction of the memory table
   localparam logic [15:0] EXP [0:26] = '{
      16'h0411, 16'h0511, 16'h0611, 16'h0711, 16'h0a11, 16'h0b11, 16'h0c11,
      16'h0d11, 16'h0e11, 16'h1011, 16'h1111, 16'h1211, 16'h1311, 16'h1411,
      16'h1611, 16'h1711, 16'h1811, 16'h1a11, 16'h1b11, 16'h1c11, 16'h0211,
      16'h0311, 16'h0132, 16'h0822, 16'h0922, 16'h1922, 16'h0011};
   dspdec_top #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dec_valid(dec_valid), .dec_op(dec_op), .dec_cycles(dec_cycles),
      .external_flag_output(external_flag_output));
   dspdec_prog_mem pm (.pm_addr(pm_addr), .pm_word(pm_word));
   always #10 pclk = ~pclk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer; an idle edge after it keeps drivers single per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      // the one-cycle decode pulse from the commit edge is still standing at this edge
      if (w)
         dv = {dec_valid, dec_op, dec_cycles};
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      apb(1'b1, a, d);
      `CHK(er, ee)
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK({er, q & m}, {1'b0, x})
   endtask
   // reset values, read-back and refused accesses
   task automatic t_regs();
      rdm(8'h04, 32'hffffffff, 32'h0);
      rdm(8'h08, 32'hffffffff, 32'h0);
      rdm(8'h14, 32'hffffffff, 32'h0);
      wr(8'h04, 32'h3f, 1'b0);
      rdm(8'h04, 32'hffffffff, 32'h3f);
      wr(8'h08, 32'h1, 1'b1);
      wr(8'h1c, 32'h1, 1'b1);
      rdm(8'h00, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      `CHK(er, 1'b1)
   endtask
   // every opcode of the table; two-word ones must not decode on the first word
   task automatic t_table();
      logic [15:0] e;
      logic [15:0] c;
      for (int i = 0; i < 27; i++)
      begin
         e = EXP[i];
         wr(8'h00, {16'h0, pm_word}, 1'b0);
         if (e[1:0] == 2'h2)
         begin
            `CHK(dv[8], 1'b0)
            pm_addr = pm_addr + 6'h1;
            @(posedge pclk);
            rdm(8'h08, 32'h3000, 32'h2000);
            c = pm_word;
            wr(8'h00, {16'h0, pm_word}, 1'b0);
            rdm(8'h10, 32'hffff, {16'h0, c});
         end
         `CHK(dv, {1'b1, e[12:8], e[6:4]})
         pm_addr = pm_addr + 6'h1;
         @(posedge pclk);
         rdm(8'h08, 32'h3fff, {18'h0, 2'h1, 1'b0, e[6:4], 1'b0, e[1:0], e[12:8]});
      end
   endtask
   task automatic fld(input logic [15:0] w, input logic [31:0] m, input logic [31:0] x);
      wr(8'h00, {16'h0, w}, 1'b0);
      rdm(8'h0c, m, x);
   endtask
   // flags f set before the return word w; n is the expected cycle count
   task automatic ret(input logic [31:0] f, input logic [15:0] w, input logic [2:0] n);
      wr(8'h04, f, 1'b0);
      wr(8'h00, {16'h0, w}, 1'b0);
      `CHK(dv, {1'b1, dspdec_pkg::OP_COND_RETURN, n})
      @(posedge pclk);
      rdm(8'h08, 32'h4000, {17'h0, n == 3'h4, 14'h0});
   endtask
   // each status-bit code sets its own bit; clear-by-one empties them again
   task automatic t_status();
      logic [3:0] s [0:6];
      s = '{4'hf, 4'h5, 4'h1, 4'h3, 4'hb, 4'hd, 4'h7};
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h00, {16'h0, 12'hbe4, s[i]}, 1'b0);
         rdm(8'h14, 32'h7f, 32'h1 << i);
         `CHK({dec_op, external_flag_output}, {dspdec_pkg::OP_STATUS_BIT_SET, i == 5})
         wr(8'h14, 32'h7f, 1'b0);
         rdm(8'h14, 32'h7f, 32'h0);
      end
      `CHK(external_flag_output, 1'b0)
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_table();
      fld(16'h5412, 32'hffff, 32'h2412);
      fld(16'h54a9, 32'h7fffff, 32'h1a01a9);
      fld(16'h9a33, 32'h7800000, 32'h1000000);
      fld(16'h3512, 32'h7800000, 32'h2800000);
      fld(16'h8b8a, 32'h700000, 32'h200000);
      ret(32'h08, 16'hec88, 3'h4);
      ret(32'h00, 16'hec88, 3'h2);
      ret(32'h10, 16'hed00, 3'h4);
      ret(32'h00, 16'hed00, 3'h2);
      ret(32'h20, 16'hec00, 3'h2);
      ret(32'h20, 16'hee00, 3'h4);
      ret(32'h00, 16'hef00, 3'h4);
      t_status();
      summarize();
   end
endmodule
